// ---- dv/testbench.sv ----
`include "twr_defs.svh"
module testbench
  import twr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] C_DONE = 32'h1 << `TWR_CTL_DONE;
  localparam logic [31:0] C_ACK = 32'h1 << `TWR_CTL_ACK_EN;
  localparam logic [31:0] C_CLAIM = 32'h1 << `TWR_CTL_CLAIM;
  localparam logic [31:0] C_EN = 32'h1 << `TWR_CTL_UNIT_EN;
  localparam logic [7:0] CTL = `TWR_OFF_CONTROL;
  logic core_clk, reset, psel, penable, pwrite, arb_lost, sleep_active, sleep_idle;
  logic [7:0] paddr, b;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, unit_clk_stop, wake_req;
  logic target_transmit, start_req, m_scl, m_sda, stuck, scl_line, sda_line, ack, e;
  logic gc, arb;
  logic [6:0] own, a;
  int errors = 0;
  int checks = 0;
  int n_tx = 0;
  int n_wake = 0;
  int n_start = 0;

  // ----------------------------------------
  // Lines, parties and event counters
  // ----------------------------------------
  // Open drain: any party pulling low wins, pull-ups give 1
  assign scl_line = !((scl_oe && !scl_o) || m_scl);
  assign sda_line = !((sda_oe && !sda_o) || m_sda);

  twr_top i_dut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .arb_lost(arb_lost), .sleep_active(sleep_active),
    .sleep_idle(sleep_idle), .unit_clk_stop(unit_clk_stop), .wake_req(wake_req),
    .target_transmit(target_transmit), .start_req(start_req));
  twr_bus_master i_master (.scl_low(m_scl), .sda_low(m_sda), .stuck(stuck),
    .scl_line(scl_line), .sda_line(sda_line), .ref_clk(core_clk));

  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end

  // Pulses last one cycle, so count them for later inspection
  always @(posedge core_clk) begin
    if (target_transmit === 1'b1) n_tx++;
    if (wake_req === 1'b1) n_wake++;
    if (start_req === 1'b1) n_start++;
  end

  // ----------------------------------------
  // Bench tasks and expectations
  // ----------------------------------------
  task automatic give_verdict();
    if (errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 100) begin
      errors++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] r;
    logic x;
    apb(1'b1, ad, d, r, x);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] ad, input logic [31:0] exp);
    logic [31:0] r;
    logic x;
    apb(1'b0, ad, 32'h0, r, x);
    check(what, r, exp);
  endtask

  // Software polls the done flag, bounded
  task automatic wait_done();
    logic [31:0] r;
    logic x;
    int n;
    n = 0;
    do begin
      apb(1'b0, CTL, 32'h0, r, x);
      n++;
    end while (r[`TWR_CTL_DONE] !== 1'b1 && n < 200);
    if (n >= 200) begin
      errors++;
      give_verdict();
    end
  endtask

  task automatic addr_phase(input logic [6:0] ad, input logic rw, output logic ak);
    i_master.start();
    i_master.send({ad, rw}, ak);
  endtask

  // Step 0 address, 1 data acknowledged, 2 data refused
  function automatic logic [31:0] code_of(input logic g, input logic l, input int step);
    logic [7:0] c;
    if (step == 0 && g) c = l ? `TWR_CODE_LOST_GC : `TWR_CODE_GC;
    else if (step == 0) c = l ? `TWR_CODE_LOST_OWN_W : `TWR_CODE_OWN_W;
    else if (step == 1) c = g ? `TWR_CODE_GC_DATA_ACK : `TWR_CODE_DATA_ACK;
    else c = g ? `TWR_CODE_GC_DATA_NACK : `TWR_CODE_DATA_NACK;
    return {24'h0, c};
  endfunction

  // Hang guard well inside the cycle budget
  initial begin
    #3000000;
    errors++;
    give_verdict();
  end

  initial begin
    reset = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    arb_lost = 0;
    sleep_active = 0;
    sleep_idle = 0;
    void'($urandom(32'ha609));
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    rd_chk("own_addr", `TWR_OFF_OWN_ADDR, 32'h0);
    rd_chk("code_rst", `TWR_OFF_CODE, {24'h0, `TWR_CODE_IDLE});
    rd_chk("buffer", `TWR_OFF_BUFFER, 32'h0);
    apb(1'b0, 8'h10, 32'h0, q, e);
    check("unmapped_err", e, 1);
    check("unmapped_data", q, 0);
    wr(`TWR_OFF_CODE, 32'hff);
    rd_chk("code_ro", `TWR_OFF_CODE, {24'h0, `TWR_CODE_IDLE});
    wr(`TWR_OFF_BUFFER, 32'h5a);
    rd_chk("collision", CTL, 32'h1 << `TWR_CTL_WCOL);
    own = 7'($urandom_range(126, 1));
    wr(`TWR_OFF_OWN_ADDR, {24'h0, own, 1'b1});
    wr(CTL, C_EN | C_ACK);
    // Strangers are never answered
    repeat (4) begin
      a = 7'($urandom_range(127, 1));
      if (a == own) a = own + 7'h1;
      addr_phase(a, 1'b0, ack);
      check("stranger_ack", ack, 0);
      i_master.stop();
    end
    // Own and broadcast address, with and without lost arbitration
    for (int i = 0; i < 4; i++) begin
      gc = i[0];
      arb = i[1];
      @(posedge core_clk);
      arb_lost <= arb;
      @(posedge core_clk);
      arb_lost <= 1'b0;
      addr_phase(gc ? `TWR_BROADCAST_ADDR : own, 1'b0, ack);
      check("addr_ack", ack, 1);
      wait_done();
      check("stretch", scl_oe, 1);
      rd_chk("addr_code", `TWR_OFF_CODE, code_of(gc, arb, 0));
      wr(CTL, C_EN | C_ACK);
      check("zero_write", scl_oe, 1);
      wr(CTL, C_DONE | C_EN | C_ACK);
      repeat (2) @(posedge core_clk);
      check("released", scl_oe, 0);
      b = 8'($urandom);
      i_master.send(b, ack);
      check("data_ack", ack, 1);
      wait_done();
      rd_chk("data_code", `TWR_OFF_CODE, code_of(gc, arb, 1));
      rd_chk("data_byte", `TWR_OFF_BUFFER, {24'h0, b});
      wr(CTL, C_DONE | C_EN);
      i_master.send(~b, ack);
      check("data_nack", ack, 0);
      wait_done();
      rd_chk("nack_code", `TWR_OFF_CODE, code_of(gc, arb, 2));
      wr(CTL, C_DONE | C_EN | C_ACK | (i == 3 ? C_CLAIM : 32'h0));
      i_master.stop();
    end
    for (int k = 0; k < 100 && n_start == 0; k++) @(posedge core_clk);
    check("start_req", n_start > 0, 1);
    // Acknowledge enable low isolates, high again restores
    wr(CTL, C_EN);
    addr_phase(own, 1'b0, ack);
    check("isolated", ack, 0);
    i_master.stop();
    wr(CTL, C_EN | C_ACK);
    addr_phase(own, 1'b1, ack);
    check("read_dir", n_tx, 1);
    i_master.stop();
    wr(`TWR_OFF_OWN_ADDR, {24'h0, own, 1'b0});
    addr_phase(`TWR_BROADCAST_ADDR, 1'b0, ack);
    check("gc_off", ack, 0);
    i_master.stop();
    // Sleep: idle keeps the unit clock, deeper modes stop it
    @(posedge core_clk);
    sleep_active <= 1'b1;
    sleep_idle <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("idle_clk", unit_clk_stop, 0);
    sleep_idle <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("deep_clk", unit_clk_stop, 1);
    addr_phase(own, 1'b0, ack);
    check("sleep_ack", ack, 1);
    check("wake", n_wake, 1);
    @(posedge core_clk);
    sleep_active <= 1'b0;
    wait_done();
    check("wake_stretch", scl_oe, 1);
    wr(CTL, C_DONE | C_EN | C_ACK);
    repeat (2) @(posedge core_clk);
    check("wake_release", scl_oe, 0);
    i_master.stop();
    check("master_stuck", stuck, 0);
    give_verdict();
  end
endmodule

// ---- dv/twr_bus_master.sv ----
module twr_bus_master (
  output logic scl_low,
  output logic sda_low,
  output logic stuck,
  input wire logic scl_line,
  input wire logic sda_line,
  input wire logic ref_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 160;

  // ----------------------------------------
  // Open-drain controller, released at start
  // ----------------------------------------
  initial begin
    scl_low = 0;
    sda_low = 0;
    stuck = 0;
  end

  // Step off the core sampling edge so line changes never race it
  task automatic align();
    @(negedge ref_clk);
    #7;
  endtask

  // Release SCL, honour stretching; bounded so a stuck target is seen
  task automatic clk_high();
    int n;
    scl_low = 0;
    n = 0;
    while (scl_line !== 1'b1 && n < 20000) begin
      #10;
      n++;
    end
    if (n >= 20000) stuck = 1;
    #HALF;
  endtask

  // START: SDA falls while SCL is high
  task automatic start();
    align();
    sda_low = 0;
    clk_high();
    sda_low = 1;
    #HALF;
    scl_low = 1;
  endtask

  // STOP: SDA rises while SCL is high
  task automatic stop();
    align();
    sda_low = 1;
    #HALF;
    clk_high();
    sda_low = 0;
    #HALF;
  endtask

  // MSB first; SDA released for the ninth clock to read the acknowledge
  task automatic send(input logic [7:0] b, output logic ack);
    align();
    for (int i = 7; i >= 0; i--) begin
      #(HALF / 2);
      sda_low = !b[i];
      #(HALF / 2);
      clk_high();
      scl_low = 1;
    end
    #(HALF / 2);
    sda_low = 0;
    #(HALF / 2);
    clk_high();
    ack = !sda_line;
    scl_low = 1;
  endtask
endmodule

// ---- inc/twr_defs.svh ----
`ifndef TWR_DEFS_SVH
`define TWR_DEFS_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define TWR_APB_AW 8
`define TWR_OFF_OWN_ADDR 8'h00
`define TWR_OFF_CONTROL 8'h04
`define TWR_OFF_CODE 8'h08
`define TWR_OFF_BUFFER 8'h0c

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define TWR_CTL_DONE 7
`define TWR_CTL_ACK_EN 6
`define TWR_CTL_CLAIM 5
`define TWR_CTL_HALT 4
`define TWR_CTL_WCOL 3
`define TWR_CTL_UNIT_EN 2
`define TWR_CTL_IRQ_EN 0

// Own address register: broadcast accept in bit 0
`define TWR_OWN_GCE 0

// ----------------------------------------------------------------------
// Condition codes, prescaler field masked to zero on read
// ----------------------------------------------------------------------
`define TWR_CODE_IDLE 8'hf8
`define TWR_CODE_OWN_W 8'h60
`define TWR_CODE_LOST_OWN_W 8'h68
`define TWR_CODE_GC 8'h70
`define TWR_CODE_LOST_GC 8'h78
`define TWR_CODE_DATA_ACK 8'h80
`define TWR_CODE_DATA_NACK 8'h88
`define TWR_CODE_GC_DATA_ACK 8'h90
`define TWR_CODE_GC_DATA_NACK 8'h98
`define TWR_CODE_MASK 8'hf8

// ----------------------------------------------------------------------
// Bit counting and reset values
// ----------------------------------------------------------------------
`define TWR_BITS_PER_BYTE 4'h8
`define TWR_BROADCAST_ADDR 7'h00
`define TWR_RST_BYTE 8'h00
`define TWR_RST_WORD 32'h0000_0000

`endif

// ---- inc/twr_pkg.sv ----
package twr_pkg;

  // ----------------------------------------------------------------------
  // Receiver states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    TWR_IDLE,
    TWR_ADDR,
    TWR_ADDR_ACK,
    TWR_DATA,
    TWR_DATA_ACK,
    TWR_HOLD,
    TWR_IGNORE
  } twr_state_t;

endpackage

// ---- verilog/twr_sync.sv ----
module twr_sync #(
  parameter int W = 2
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  // Two stages; first stage feeds only the second
  always_comb begin
    meta_d = d;
    q_d = meta_q;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_q <= '1;
      q <= '1;
    end else begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end

endmodule

// ---- verilog/twr_top.sv ----
`include "twr_defs.svh"
// Function
// R1 - respond only when upper seven address bits match
// R2 - bit zero enables broadcast address response
// R3 - software sets unit enable first
// R4 - software sets acknowledge enable for addressing
// R5 - software writes claim and halt zero
// R6 - write bit enters receive, read enters transmit
// R7 - own write address sets done, valid code
// R8 - lost arbitration reports 0x68 or 0x78
// R9 - cleared acknowledge enable gives data not-acknowledge
// R10 - no address acknowledge while acknowledge enable low
// R11 - unit clock stopped in deep sleep
// R12 - sleeping address match acknowledged and wakes part
// R13 - hold clock low until done cleared
// R14 - done cleared by writing one
// R15 - byte buffer stale after address wake-up
// R16 - code 0x60 own write address acknowledged
// R17 - code 0x70 broadcast address acknowledged
// R18 - code 0x80 data byte acknowledged
// R19 - code 0x88 then unaddressed without recognition
// R20 - prescaler bits of code read as zero
// R21 - after 0x88 acknowledge enable restores recognition
// R22 - after 0x88 claim bit requests start
// R23 - code stable, clock stretched while done set
module twr_top
  import twr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TWR_APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic arb_lost,
  input wire logic sleep_active,
  input wire logic sleep_idle,
  output logic unit_clk_stop,
  output logic wake_req,
  output logic target_transmit,
  output logic start_req
);

  // ----------------------------------------------------------------------
  // Bus pin synchronisers and edge finding
  // ----------------------------------------------------------------------
  logic scl_s, sda_s;
  logic scl_prev_q, sda_prev_q, scl_prev_d, sda_prev_d;
  logic busy_q, busy_d;
  logic scl_rise, scl_fall, start_det, stop_det;

  twr_sync #(.W(2)) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .d({scl_i, sda_i}),
    .q({scl_s, sda_s})
  );

  // Conditions seen on the synchronised lines only
  always_comb begin
    scl_prev_d = scl_s;
    sda_prev_d = sda_s;
    scl_rise = scl_s & ~scl_prev_q;
    scl_fall = ~scl_s & scl_prev_q;
    start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    busy_d = start_det ? 1'b1 : (stop_det ? 1'b0 : busy_q);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      scl_prev_q <= scl_prev_d;
      sda_prev_q <= sda_prev_d;
      busy_q <= busy_d;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  logic [7:0] own_q, own_d, code_q, code_d, buf_q, buf_d, shift_q, shift_d;
  logic ack_en_q, ack_en_d, claim_q, claim_d, halt_q, halt_d;
  logic wcol_q, wcol_d, en_q, en_d, irq_en_q, irq_en_d, done_q, done_d;
  logic [31:0] rdata_q, rdata_d;
  logic setup, access, wr_own, wr_ctl, wr_buf, mapped;
  logic done_set, buf_load;
  logic [7:0] code_new;

  // Address test of a received byte against the own address word
  function automatic logic own_hit(input logic [7:0] rx, input logic [7:0] own);
    own_hit = (rx[7:1] == own[7:1]);
  endfunction

  function automatic logic gc_hit(input logic [7:0] rx, input logic [7:0] own);
    gc_hit = (rx[7:1] == `TWR_BROADCAST_ADDR) & own[`TWR_OWN_GCE];
  endfunction

  // Zero-wait slave: read data captured in setup, answered in access
  always_comb begin
    setup = psel & ~penable;
    access = psel & penable;
    mapped = (paddr == `TWR_OFF_OWN_ADDR) | (paddr == `TWR_OFF_CONTROL) |
             (paddr == `TWR_OFF_CODE) | (paddr == `TWR_OFF_BUFFER);
    wr_own = access & pwrite & (paddr == `TWR_OFF_OWN_ADDR);
    wr_ctl = access & pwrite & (paddr == `TWR_OFF_CONTROL);
    wr_buf = access & pwrite & (paddr == `TWR_OFF_BUFFER);
    pready = access;
    pslverr = access & ~mapped;
    prdata = rdata_q;
    rdata_d = rdata_q;
    if (setup) begin
      rdata_d = `TWR_RST_WORD;
      case (paddr)
        `TWR_OFF_OWN_ADDR: rdata_d[7:0] = own_q;
        `TWR_OFF_CONTROL: begin
          rdata_d[`TWR_CTL_DONE] = done_q;
          rdata_d[`TWR_CTL_ACK_EN] = ack_en_q;
          rdata_d[`TWR_CTL_CLAIM] = claim_q;
          rdata_d[`TWR_CTL_HALT] = halt_q;
          rdata_d[`TWR_CTL_WCOL] = wcol_q;
          rdata_d[`TWR_CTL_UNIT_EN] = en_q;
          rdata_d[`TWR_CTL_IRQ_EN] = irq_en_q;
        end
        `TWR_OFF_CODE: rdata_d[7:0] = code_q & `TWR_CODE_MASK; // R20
        `TWR_OFF_BUFFER: rdata_d[7:0] = buf_q;
        default: rdata_d = `TWR_RST_WORD;
      endcase
    end
    own_d = wr_own ? pwdata[7:0] : own_q;
    ack_en_d = wr_ctl ? pwdata[`TWR_CTL_ACK_EN] : ack_en_q;
    claim_d = wr_ctl ? pwdata[`TWR_CTL_CLAIM] : claim_q;
    halt_d = wr_ctl ? pwdata[`TWR_CTL_HALT] : halt_q;
    en_d = wr_ctl ? pwdata[`TWR_CTL_UNIT_EN] : en_q;
    irq_en_d = wr_ctl ? pwdata[`TWR_CTL_IRQ_EN] : irq_en_q;
    // Hardware set beats a software clear in the same cycle
    if (done_set) begin
      done_d = 1'b1;
    end else if (wr_ctl & pwdata[`TWR_CTL_DONE]) begin
      done_d = 1'b0; // R14
    end else begin
      done_d = done_q;
    end
    // Buffer writes only allowed while the flag is up
    wcol_d = wr_buf ? ~done_q : wcol_q;
    buf_d = buf_q;
    if (wr_buf & done_q) begin
      buf_d = pwdata[7:0];
    end
    if (buf_load) begin
      buf_d = shift_q;
    end
    // Code changes only when the flag sets
    code_d = done_set ? code_new : code_q; // R23
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      own_q <= `TWR_RST_BYTE;
      ack_en_q <= 1'b0;
      claim_q <= 1'b0;
      halt_q <= 1'b0;
      wcol_q <= 1'b0;
      en_q <= 1'b0;
      irq_en_q <= 1'b0;
      done_q <= 1'b0;
      code_q <= `TWR_CODE_IDLE;
      buf_q <= `TWR_RST_BYTE;
      rdata_q <= `TWR_RST_WORD;
    end else begin
      own_q <= own_d;
      ack_en_q <= ack_en_d;
      claim_q <= claim_d;
      halt_q <= halt_d;
      wcol_q <= wcol_d;
      en_q <= en_d;
      irq_en_q <= irq_en_d;
      done_q <= done_d;
      code_q <= code_d;
      buf_q <= buf_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // Target receiver
  // ----------------------------------------------------------------------
  twr_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic gc_q, gc_d, lost_q, lost_d, nack_q, nack_d, woke_q, woke_d;
  logic pend_q, pend_d, sda_drv_q, sda_drv_d;
  logic byte_end, hit, accept, deep_sleep;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    gc_d = gc_q;
    nack_d = nack_q;
    woke_d = woke_q;
    sda_drv_d = sda_drv_q;
    done_set = 1'b0;
    buf_load = 1'b0;
    code_new = code_q;
    wake_req = 1'b0;
    target_transmit = 1'b0;
    deep_sleep = sleep_active & ~sleep_idle;
    unit_clk_stop = deep_sleep; // R11
    byte_end = scl_fall & (cnt_q == `TWR_BITS_PER_BYTE);
    hit = own_hit(shift_q, own_q) | gc_hit(shift_q, own_q); // R1 R2
    accept = en_q & ack_en_q & hit; // R10
    lost_d = arb_lost ? 1'b1 : lost_q;
    // Restart after a flag clear that left the unit unaddressed
    pend_d = pend_q;
    if (~busy_q & pend_q) begin
      pend_d = 1'b0;
    end
    // Shifting stops after eight bits so the ack clock leaves the byte intact
    if (scl_rise && (cnt_q < `TWR_BITS_PER_BYTE)) begin
      shift_d = {shift_q[6:0], sda_s};
      cnt_d = cnt_q + 4'h1;
    end
    case (state_q)
      TWR_IDLE, TWR_IGNORE: begin
        sda_drv_d = 1'b0;
      end
      TWR_ADDR: begin
        if (byte_end) begin
          if (accept & ~shift_q[0]) begin // R6
            state_d = TWR_ADDR_ACK;
            sda_drv_d = 1'b1;
            gc_d = ~own_hit(shift_q, own_q);
            if (deep_sleep) begin
              wake_req = 1'b1; // R12
              woke_d = 1'b1;
            end
          end else begin
            target_transmit = accept & shift_q[0];
            state_d = TWR_IGNORE;
          end
        end
      end
      TWR_ADDR_ACK: begin
        if (scl_fall) begin
          state_d = TWR_HOLD;
          sda_drv_d = 1'b0;
          done_set = 1'b1; // R7
          nack_d = 1'b0;
          lost_d = 1'b0;
          if (gc_q) begin
            code_new = lost_q ? `TWR_CODE_LOST_GC : `TWR_CODE_GC; // R8 R17
          end else begin
            code_new = lost_q ? `TWR_CODE_LOST_OWN_W : `TWR_CODE_OWN_W; // R8 R16
          end
        end
      end
      TWR_DATA: begin
        if (byte_end) begin
          state_d = TWR_DATA_ACK;
          sda_drv_d = ack_en_q; // R9
          nack_d = ~ack_en_q;
        end
      end
      TWR_DATA_ACK: begin
        if (scl_fall) begin
          state_d = TWR_HOLD;
          sda_drv_d = 1'b0;
          done_set = 1'b1;
          buf_load = ~woke_q; // R15
          if (gc_q) begin
            code_new = nack_q ? `TWR_CODE_GC_DATA_NACK : `TWR_CODE_GC_DATA_ACK;
          end else begin
            code_new = nack_q ? `TWR_CODE_DATA_NACK : `TWR_CODE_DATA_ACK; // R18 R19
          end
        end
      end
      TWR_HOLD: begin
        // Clock held low until software drops the flag
        if (~done_q) begin
          woke_d = 1'b0;
          cnt_d = 4'h0;
          if (nack_q) begin
            state_d = TWR_IDLE; // R19 R21
            pend_d = claim_q; // R22
          end else begin
            state_d = TWR_DATA;
          end
        end
      end
      default: begin
        state_d = TWR_IDLE;
      end
    endcase
    // Bus conditions override, except while stretching
    if (state_q != TWR_HOLD) begin
      if (start_det & en_q) begin
        state_d = TWR_ADDR;
        cnt_d = 4'h0;
        sda_drv_d = 1'b0;
      end else if (stop_det) begin
        state_d = TWR_IDLE;
        sda_drv_d = 1'b0;
        lost_d = 1'b0;
      end
    end
    if (~en_q) begin
      state_d = TWR_IDLE;
      sda_drv_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= TWR_IDLE;
      cnt_q <= 4'h0;
      shift_q <= `TWR_RST_BYTE;
      gc_q <= 1'b0;
      lost_q <= 1'b0;
      nack_q <= 1'b0;
      woke_q <= 1'b0;
      pend_q <= 1'b0;
      sda_drv_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      gc_q <= gc_d;
      lost_q <= lost_d;
      nack_q <= nack_d;
      woke_q <= woke_d;
      pend_q <= pend_d;
      sda_drv_q <= sda_drv_d;
    end
  end

  // Open-drain drive: only ever pull low
  always_comb begin
    scl_o = 1'b0;
    sda_o = 1'b0;
    scl_oe = (state_q == TWR_HOLD); // R13 R23
    sda_oe = sda_drv_q;
    start_req = pend_q & ~busy_q; // R22
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_addr_taken;
    (state_q == TWR_ADDR) && byte_end && accept && !shift_q[0];
  endsequence

  sequence s_ack_slot;
    (state_q == TWR_ADDR_ACK) && sda_oe;
  endsequence

  a_addr_match_ack: assert property (s_addr_taken |=> s_ack_slot) // R1
    else $error("matching address not acknowledged");
  a_gc_ignored: assert property ((state_q == TWR_ADDR) && byte_end &&
      shift_q[7:1] == `TWR_BROADCAST_ADDR && !own_q[0] && own_q[7:1] != 7'h00
      |=> state_q != TWR_ADDR_ACK) // R2
    else $error("broadcast address taken while disabled");
  a_no_ack_off: assert property ((state_q == TWR_ADDR) && byte_end && !ack_en_q
      |=> !sda_oe) // R10
    else $error("address acknowledged with acknowledge disabled");
  a_done_after_ack: assert property ((s_ack_slot and scl_fall)
      |=> done_q && scl_oe) // R7
    else $error("done flag missing after address");
  a_data_nack: assert property ((state_q == TWR_DATA) && byte_end && !ack_en_q
      |=> !sda_oe ##0 nack_q) // R9
    else $error("data acknowledged with acknowledge disabled");
  a_code_stable: assert property (done_q && $past(done_q) |-> $stable(code_q)) // R23
    else $error("code changed while done set");
  a_stretch_hold: assert property ($rose(done_q) |-> scl_oe [*2]) // R13
    else $error("clock not held after done");
  a_clear_one: assert property (done_q && wr_ctl && pwdata[`TWR_CTL_DONE] && !done_set
      |=> !done_q ##1 !scl_oe) // R14
    else $error("done not cleared by writing one");
  a_code_masked: assert property (setup && paddr == `TWR_OFF_CODE
      |=> rdata_q[2:0] == 3'h0) // R20
    else $error("prescaler bits visible in code");
  a_wake_pulse: assert property ((s_addr_taken and deep_sleep) |-> wake_req ##1 woke_q) // R12
    else $error("no wake on sleeping address match");
  a_lost_code: assert property ($rose(done_q) && $past(lost_q) && $past(state_q) ==
      TWR_ADDR_ACK && !$past(gc_q) |-> code_q == `TWR_CODE_LOST_OWN_W) // R8
    else $error("lost arbitration code wrong");

endmodule
